//--- pkg/tfr_pkg.sv
// constants for the test feature and ring oscillator block
// assumes a 50 MHz core clock and an APB register bus with 32-bit data
package tfr_pkg;
    localparam int          APB_AW       = 8;
    localparam int          DATA_W       = 32;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          RO_NUM       = 8;
    localparam int          RO_CNT_W     = 12;
    localparam int          PULSE_CNT_W  = 4;
    localparam int          GP_NUM       = 4;
    localparam int          MON_W        = 4;
    // register byte addresses
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_GP_SEL  = 8'h04;
    localparam logic [7:0]  ADDR_MON_SEL = 8'h08;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0C;
    localparam logic [7:0]  ADDR_RD_DATA = 8'h10;
    localparam logic [7:0]  ADDR_BSCAN   = 8'h14;
    localparam logic [7:0]  ADDR_PULSES  = 8'h18;
    localparam logic [7:0]  ADDR_RO_BASE = 8'h20;
    // reset values
    localparam logic [1:0]  CTRL_RST     = 2'h0;
    localparam logic [7:0]  GP_SEL_RST   = 8'h00;
    localparam logic [3:0]  MON_SEL_RST  = 4'h0;
    // record layout
    localparam int          ADDR_W       = 16;
    localparam int          CHARGE_W     = 4;
    localparam int          HDR_MARK_W   = 7;
    localparam logic [6:0]  HDR_MARK     = 7'h01;
    localparam int          TRIG_ID_W    = 5;
    localparam int          TRIG_TAG_W   = 5;
    localparam int          BCID_W       = 15;
    // serializer frames
    localparam logic [31:0] IDLE_WORD    = 32'h7800_0000;
    localparam logic [7:0]  SVC_TAG      = 8'hB4;
    localparam logic [4:0]  BIT_LAST     = 5'h1F;
    localparam logic [2:0]  SVC_LAST     = 3'h7;
    localparam logic [6:0]  PRBS7_SEED   = 7'h7F;
    localparam logic [30:0] PRBS31_SEED  = 31'h7FFF_FFFF;
    typedef enum logic [1:0] {
        TFR_PAT_FRAMED,
        TFR_PAT_CLOCK,
        TFR_PAT_PRBS7,
        TFR_PAT_PRBS31
    } tfr_pat_t;
    // output select codes of a general-purpose output
    localparam logic [1:0]  GP_SRC_HITOR = 2'h0;
    localparam logic [1:0]  GP_SRC_PULSE = 2'h1;
    localparam logic [1:0]  GP_SRC_TX    = 2'h2;
    localparam logic [1:0]  GP_SRC_DATA  = 2'h3;
endpackage

//--- logic/tfr_fifo.sv
// record fifo with a registered output stage
// assumes one clock, synchronous active-low reset, clock enable
`timescale 1ns/1ns
module tfr_fifo #(
    parameter int W = 32,
    parameter int D = 16
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         ce_in,
    input  wire logic         in_valid_in,
    output wire logic         in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output wire logic         out_valid_out,
    input  wire logic         out_ready_in,
    output wire logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          ov_r;
    logic [W-1:0]  od_r;
    wire           push = in_valid_in && in_ready_out;
    wire           load = (!ov_r || out_ready_in) && (cnt_r != '0);
    assign in_ready_out  = (cnt_r != (AW+1)'(D));
    assign out_valid_out = ov_r;
    assign out_data_out  = od_r;

    always_ff @(posedge clk_in) begin
        if (ce_in && push) begin
            mem[wp_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            ov_r  <= 1'b0;
            od_r  <= '0;
        end else if (ce_in) begin
            if (push) wp_r <= wp_r + 1'b1;
            if (load) begin
                rp_r <= rp_r + 1'b1;
                od_r <= mem[rp_r];
                ov_r <= 1'b1;
            end else if (out_ready_in) begin
                ov_r <= 1'b0;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
        end
    end
endmodule // tfr_fifo

//--- logic/tfr_top.sv
// test features: record capture, heartbeat serializer, fixed patterns,
// register readout of records, voted control register, output and monitor selects,
// ring oscillator counters. assumes APB master, async pixel and ring inputs.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
// Notes on behaviour
// - hit record is address then four charges
// - reserved address range (top 7 bits equal to mark) marks event header
// - header is mark, trigger id, tag, bunch count
// - serializer runs without any input lock
// - free-running output sends idle and service frames
// - config selects clock, prbs7 or prbs31 pattern
// - records readable over register port, unencoded
// - scan exposes all three voted register copies
// - four outputs selectable, reset to hit-or
// - monitor channel set by select register
// - each ring oscillator clocks 12-bit counter
// - 4-bit counter counts gate pulses
// - counters advance only while gate high
// - gate pulse comes from global pulse command
// - writing a counter address clears it
module tfr_top
    import tfr_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  ce_in,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [APB_AW-1:0]     paddr_in,
    input  wire logic [DATA_W-1:0]     pwdata_in,
    output wire logic [DATA_W-1:0]     prdata_out,
    output wire logic                  pready_out,
    output wire logic                  pslverr_out,
    input  wire logic                  hit_valid_in,
    input  wire logic [ADDR_W-1:0]     hit_addr_in,
    input  wire logic [15:0]           hit_charge_in,
    input  wire logic                  hdr_valid_in,
    input  wire logic [TRIG_ID_W-1:0]  trig_id_in,
    input  wire logic [TRIG_TAG_W-1:0] trig_tag_in,
    input  wire logic [BCID_W-1:0]     bcid_in,
    output wire logic                  rec_ready_out,
    input  wire logic                  lock_in,
    input  wire logic                  global_pulse_in,
    input  wire logic [RO_NUM-1:0]     ring_tick_in,
    input  wire logic [GP_NUM-1:0]     hit_or_in,
    output wire logic                  tx_bit_out,
    output wire logic [GP_NUM-1:0]     gp_lvds_out,
    output wire logic [MON_W-1:0]      monitor_channel_select_out
);
    // apb decode
    wire        setup    = psel_in && !penable_in;
    wire        access   = psel_in && penable_in;
    wire        wr_en    = access && pwrite_in;
    wire        is_ro    = (paddr_in[7:5] == ADDR_RO_BASE[7:5]) && (paddr_in[1:0] == 2'h0);
    wire [2:0]  ro_idx   = paddr_in[4:2];
    wire        hit_ctrl = (paddr_in == ADDR_CTRL);
    wire        hit_gp   = (paddr_in == ADDR_GP_SEL);
    wire        hit_mon  = (paddr_in == ADDR_MON_SEL);
    wire        hit_stat = (paddr_in == ADDR_STATUS);
    wire        hit_rd   = (paddr_in == ADDR_RD_DATA);
    wire        hit_bs   = (paddr_in == ADDR_BSCAN);
    wire        hit_pc   = (paddr_in == ADDR_PULSES);
    wire        mapped   = hit_ctrl | hit_gp | hit_mon | hit_stat | hit_rd | hit_bs | hit_pc | is_ro;
    assign pready_out  = 1'b1;
    assign pslverr_out = access && !mapped;

    // config registers; control held in three copies and voted
    logic [1:0]        ctrl_a_r, ctrl_b_r, ctrl_c_r;
    logic [7:0]        gp_sel_r;
    logic [MON_W-1:0]  mon_sel_r;
    wire  [1:0]        ctrl_vote = (ctrl_a_r & ctrl_b_r) | (ctrl_a_r & ctrl_c_r) | (ctrl_b_r & ctrl_c_r);
    wire  tfr_pat_t    pattern   = tfr_pat_t'(ctrl_vote);

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ctrl_a_r  <= CTRL_RST;
            ctrl_b_r  <= CTRL_RST;
            ctrl_c_r  <= CTRL_RST;
            gp_sel_r  <= GP_SEL_RST;
            mon_sel_r <= MON_SEL_RST;
        end else if (ce_in && wr_en) begin
            if (hit_ctrl) begin
                ctrl_a_r <= pwdata_in[1:0];
                ctrl_b_r <= pwdata_in[1:0];
                ctrl_c_r <= pwdata_in[1:0];
            end
            if (hit_gp) gp_sel_r <= pwdata_in[7:0];
            if (hit_mon) mon_sel_r <= pwdata_in[MON_W-1:0];
        end
    end
    assign monitor_channel_select_out = mon_sel_r;

    // synchronisers for async pins
    logic [RO_NUM-1:0] ring_s1_r, ring_s2_r, ring_d_r;
    logic [GP_NUM-1:0] hor_s1_r, hor_s2_r;
    logic              lock_s1_r, lock_s2_r;
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ring_s1_r <= '0;
            ring_s2_r <= '0;
            ring_d_r  <= '0;
            hor_s1_r  <= '0;
            hor_s2_r  <= '0;
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
        end else if (ce_in) begin
            ring_s1_r <= ring_tick_in;
            ring_s2_r <= ring_s1_r;
            ring_d_r  <= ring_s2_r;
            hor_s1_r  <= hit_or_in;
            hor_s2_r  <= hor_s1_r;
            lock_s1_r <= lock_in;
            lock_s2_r <= lock_s1_r;
        end
    end

    // record builder
    wire        hit_reserved = (hit_addr_in[15:9] == HDR_MARK);
    // reserved address never passes as hit data
    wire        rec_valid    = hdr_valid_in || (hit_valid_in && !hit_reserved);
    wire [31:0] hdr_word     = {HDR_MARK, trig_id_in, trig_tag_in, bcid_in};
    wire [31:0] hit_word     = {hit_addr_in, hit_charge_in};
    wire [31:0] rec_data     = hdr_valid_in ? hdr_word : hit_word;
    wire        fifo_ov;
    wire [31:0] fifo_od;
    wire        fifo_pop;

    tfr_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .ce_in         (ce_in),
        .in_valid_in   (rec_valid),
        .in_ready_out  (rec_ready_out),
        .in_data_in    (rec_data),
        .out_valid_out (fifo_ov),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_od)
    );

    // ring oscillator counters and gate pulse counter
    logic                   gate_d_r;
    logic [PULSE_CNT_W-1:0] pulse_cnt_r;
    logic [RO_CNT_W-1:0]    ro_cnt_r [RO_NUM];
    wire                    gate_rise = global_pulse_in && !gate_d_r;
    wire                    pc_clr    = wr_en && hit_pc;
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            gate_d_r    <= 1'b0;
            pulse_cnt_r <= '0;
        end else if (ce_in) begin
            gate_d_r <= global_pulse_in;
            if (pc_clr) pulse_cnt_r <= '0;
            else if (gate_rise) pulse_cnt_r <= pulse_cnt_r + 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < RO_NUM; gi++) begin : g_ro
            wire tick = ring_s2_r[gi] && !ring_d_r[gi];
            wire clr  = wr_en && is_ro && (ro_idx == 3'(gi));
            always_ff @(posedge clk_in) begin
                if (!rst_b_in) begin
                    ro_cnt_r[gi] <= '0;
                end else if (ce_in) begin
                    if (clr) ro_cnt_r[gi] <= '0;
                    else if (tick && global_pulse_in) ro_cnt_r[gi] <= ro_cnt_r[gi] + 1'b1;
                end
            end
        end
    endgenerate

    // read mux, captured in the setup cycle
    logic [31:0] prdata_r;
    logic        pop_ok_r;
    wire  [31:0] rd_mux =
        hit_ctrl ? {30'h0, ctrl_vote} :
        hit_gp   ? {24'h0, gp_sel_r} :
        hit_mon  ? {28'h0, mon_sel_r} :
        hit_stat ? {29'h0, lock_s2_r, !rec_ready_out, !fifo_ov} :
        hit_rd   ? fifo_od :
        hit_bs   ? {26'h0, ctrl_c_r, ctrl_b_r, ctrl_a_r} :
        hit_pc   ? {28'h0, pulse_cnt_r} :
        is_ro    ? {20'h0, ro_cnt_r[ro_idx]} : 32'h0000_0000;
    assign fifo_pop = access && !pwrite_in && hit_rd && pop_ok_r;
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            prdata_r <= '0;
            pop_ok_r <= 1'b0;
        end else if (ce_in && setup) begin
            prdata_r <= rd_mux;
            pop_ok_r <= fifo_ov;
        end
    end
    assign prdata_out = prdata_r;

    // serializer; runs regardless of lock
    logic [31:0] shift_r;
    logic [4:0]  bit_cnt_r;
    logic [2:0]  frame_cnt_r;
    logic [6:0]  prbs7_r;
    logic [30:0] prbs31_r;
    logic        tx_bit_r;
    logic        tx_nxt;
    wire         frame_end = (bit_cnt_r == BIT_LAST);
    wire         svc_now   = (frame_cnt_r == SVC_LAST);
    wire  [31:0] svc_word  = {SVC_TAG, 4'h0, mon_sel_r, 8'h00, 5'h00, lock_s2_r, ctrl_vote};
    always_comb begin
        case (pattern)
            TFR_PAT_FRAMED: tx_nxt = shift_r[31];
            TFR_PAT_CLOCK:  tx_nxt = !tx_bit_r;
            TFR_PAT_PRBS7:  tx_nxt = prbs7_r[6];
            TFR_PAT_PRBS31: tx_nxt = prbs31_r[30];
            default:        tx_nxt = 1'b0;
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            shift_r     <= IDLE_WORD;
            bit_cnt_r   <= '0;
            frame_cnt_r <= '0;
            prbs7_r     <= PRBS7_SEED;
            prbs31_r    <= PRBS31_SEED;
            tx_bit_r    <= 1'b0;
        end else if (ce_in) begin
            tx_bit_r  <= tx_nxt;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            prbs7_r   <= {prbs7_r[5:0], prbs7_r[6] ^ prbs7_r[5]};
            prbs31_r  <= {prbs31_r[29:0], prbs31_r[30] ^ prbs31_r[27]};
            if (frame_end) begin
                frame_cnt_r <= frame_cnt_r + 1'b1;
                shift_r     <= svc_now ? svc_word : IDLE_WORD;
            end else begin
                shift_r <= {shift_r[30:0], 1'b0};
            end
        end
    end
    assign tx_bit_out = tx_bit_r;

    // general-purpose outputs
    logic [GP_NUM-1:0] gp_r;
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            gp_r <= '0;
        end else if (ce_in) begin
            for (int i = 0; i < GP_NUM; i++) begin
                case (gp_sel_r[2*i +: 2])
                    GP_SRC_HITOR: gp_r[i] <= hor_s2_r[i];
                    GP_SRC_PULSE: gp_r[i] <= global_pulse_in;
                    GP_SRC_TX:    gp_r[i] <= tx_bit_r;
                    GP_SRC_DATA:  gp_r[i] <= fifo_ov;
                    default:      gp_r[i] <= 1'b0;
                endcase
            end
        end
    end
    assign gp_lvds_out = gp_r;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_hit_layout: assert property (hit_valid_in && !hdr_valid_in && !hit_reserved |->
        rec_valid && rec_data[31:16] == hit_addr_in && rec_data[15:0] == hit_charge_in)
        else $error("hit record layout wrong");
    a_reserved_drop: assert property (hit_valid_in && !hdr_valid_in && hit_reserved |-> !rec_valid)
        else $error("reserved address passed as hit");
    a_header_mark: assert property (hdr_valid_in |-> rec_data[31:25] == HDR_MARK
        && rec_data[14:0] == bcid_in) else $error("header layout wrong");
    a_service_frame: assert property (ce_in && frame_end && svc_now |=> shift_r[31:24] == SVC_TAG)
        else $error("service frame missing");
    a_clock_toggle: assert property (ce_in && pattern == TFR_PAT_CLOCK |=> tx_bit_out != $past(tx_bit_out))
        else $error("clock pattern did not toggle");
    a_record_readout: assert property (ce_in && fifo_pop |=> !fifo_ov || fifo_od != $past(fifo_od))
        else $error("record not popped");
    a_scan_copies: assert property (ce_in && wr_en && hit_ctrl |=> ctrl_a_r == ctrl_b_r
        && ctrl_b_r == ctrl_c_r) else $error("copies differ after write");
    a_gp_hitor: assert property (ce_in && gp_sel_r[1:0] == GP_SRC_HITOR |=> gp_lvds_out[0] == $past(hor_s2_r[0]))
        else $error("hit-or not routed");
    a_mon_write: assert property (ce_in && wr_en && hit_mon |=> monitor_channel_select_out
        == $past(pwdata_in[MON_W-1:0])) else $error("monitor select not written");
    a_pulse_count: assert property (ce_in && gate_rise && !pc_clr |=> pulse_cnt_r
        == $past(pulse_cnt_r) + 1'b1) else $error("gate pulse not counted");
    a_ro_hold: assert property (ce_in && !global_pulse_in && !(wr_en && is_ro) |=> ro_cnt_r[0]
        == $past(ro_cnt_r[0])) else $error("counter moved with gate low");
    a_ro_clear: assert property (ce_in && wr_en && is_ro && ro_idx == 3'h0 |=> ro_cnt_r[0] == '0)
        else $error("counter not cleared");
    a_prbs_live: assert property (prbs7_r != '0 && prbs31_r != '0)
        else $error("prbs register stuck at zero");

    c_fifo_full: cover property (!rec_ready_out);
    c_pulse_seen: cover property (ce_in && gate_rise ##[1:20] ce_in && !global_pulse_in);
    c_service: cover property (ce_in && frame_end && svc_now);
endmodule // tfr_top

//--- dv/tfr_daq_model.sv
// daq-side partner: deserialises the line and issues global pulses
// assumes one line bit per clock, newest bit lands in word_out[0]
`timescale 1ns/1ns
module tfr_daq_model
    import tfr_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        tx_bit_in,
    output logic             pulse_out,
    output logic [31:0]      word_out,
    output logic             pump_a_out,
    output logic             pump_b_out
);
    logic [1:0] ph_r;
    initial pulse_out = 1'b0;
    // pump phases with dead time, never overlapping
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ph_r       <= 2'h0;
            pump_a_out <= 1'b0;
            pump_b_out <= 1'b0;
        end else begin
            ph_r       <= ph_r + 2'h1;
            pump_a_out <= (ph_r == 2'h0);
            pump_b_out <= (ph_r == 2'h2);
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            word_out <= 32'h0000_0000;
        end else begin
            word_out <= {word_out[30:0], tx_bit_in};
        end
    end
    task automatic gate(input int len);
        @(posedge clk_in);
        pulse_out <= 1'b1;
        repeat (len) @(posedge clk_in);
        pulse_out <= 1'b0;
    endtask
    function automatic logic is_header(input logic [31:0] w);
        return w[31:25] === HDR_MARK;
    endfunction
endmodule // tfr_daq_model

//--- dv/test_features_and_ring_osc_bench.sv
// self-checking bench for the test feature block
// assumes the daq model on the line and an apb master made of tasks
`timescale 1ns/1ns
module test_features_and_ring_osc_bench import tfr_pkg::*;;
    logic        clk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1, lock_in = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic        hit_valid_in = 1'b0, hdr_valid_in = 1'b0, e;
    logic [7:0]  paddr_in = 8'h00, ring_tick_in = 8'h00, gsel, mask;
    logic [31:0] pwdata_in = 32'h0, r, w, v;
    logic [15:0] hit_addr_in = 16'h0, hit_charge_in = 16'h0;
    logic [4:0]  trig_id_in = 5'h0, trig_tag_in = 5'h0;
    logic [14:0] bcid_in = 15'h0;
    logic [3:0]  hit_or_in = 4'h0;
    wire logic [31:0] prdata_out, word;
    wire logic        pready_out, pslverr_out, rec_ready_out, tx_bit_out, global_pulse_in;
    wire logic        pump_a, pump_b;
    wire logic [3:0]  gp_lvds_out, monitor_channel_select_out;
    int          mismatches = 0, tests_run = 0, n;
    logic [31:0] q[$];
    always #10 clk_in = ~clk_in;
    tfr_top DUT (.clk_in, .rst_b_in, .ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .hit_valid_in, .hit_addr_in,
        .hit_charge_in, .hdr_valid_in, .trig_id_in, .trig_tag_in, .bcid_in, .rec_ready_out,
        .lock_in, .global_pulse_in, .ring_tick_in, .hit_or_in, .tx_bit_out, .gp_lvds_out,
        .monitor_channel_select_out);
    tfr_daq_model daq (.clk_in, .rst_b_in, .tx_bit_in(tx_bit_out), .pulse_out(global_pulse_in),
        .word_out(word), .pump_a_out(pump_a), .pump_b_out(pump_b));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic timeout();
        chk(32'h0, 32'h1);
        tally_and_finish();
    endtask
    function automatic logic [31:0] svc(input logic [3:0] m, input logic l, input logic [1:0] c);
        return {SVC_TAG, 4'h0, m, 8'h00, 5'h00, l, c};
    endfunction
    function automatic logic [31:0] exp_rec(input logic h, input logic [31:0] x);
        return h ? {HDR_MARK, x[24:0]} : x;
    endfunction
    function automatic logic [31:0] rhit();
        logic [31:0] x;
        x = $urandom;
        if (x[31:25] == HDR_MARK) x[31] = 1'b1;
        return x;
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (pready_out !== 1'b1 && k < 20);
        if (k >= 20) timeout();
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic err);
        apb(1'b0, a, 32'h0);
        chk(r, x);
        chk(e, err);
    endtask
    task automatic push(input logic h, input logic [31:0] x);
        int k;
        hdr_valid_in <= h;
        hit_valid_in <= !h;
        {trig_id_in, trig_tag_in, bcid_in} <= x[24:0];
        {hit_addr_in, hit_charge_in} <= x;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (rec_ready_out !== 1'b1 && k < 50);
        if (k >= 50) timeout();
    endtask
    task automatic waitw(input logic [31:0] x, input int lim);
        int k;
        k = 0;
        while (word !== x && k < lim) begin
            @(posedge clk_in);
            k++;
        end
        if (k >= lim) timeout();
        chk(word, x);
    endtask
    task automatic gp_check(input logic ne);
        logic [3:0] h1, h2, h3, x;
        logic       p1, t1;
        for (int k = 0; k < 24; k++) begin
            @(posedge clk_in);
            for (int i = 0; i < 4; i++) begin
                case (gsel[2*i +: 2])
                    GP_SRC_HITOR: x[i] = h3[i];
                    GP_SRC_PULSE: x[i] = p1;
                    GP_SRC_TX:    x[i] = t1;
                    default:      x[i] = ne;
                endcase
            end
            if (k > 3) chk(gp_lvds_out, x);
            {h3, h2, h1, p1, t1} = {h2, h1, hit_or_in, global_pulse_in, tx_bit_out};
            hit_or_in <= 4'($urandom);
        end
    endtask
    task automatic ticks(input logic [7:0] m, input int cnt);
        repeat (cnt) begin
            @(posedge clk_in);
            ring_tick_in <= m;
            repeat (3) @(posedge clk_in);
            ring_tick_in <= 8'h00;
            repeat (2) @(posedge clk_in);
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk_in);
        timeout();
    end
    initial begin
        void'($urandom(4471));
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        waitw(IDLE_WORD, 100);
        waitw(svc(4'h0, 1'b0, 2'h0), 600);
        rdc(ADDR_CTRL, 32'(CTRL_RST), 1'b0);
        rdc(ADDR_STATUS, 32'h1, 1'b0);
        rdc(8'h1C, 32'h0, 1'b1);
        gsel = GP_SEL_RST;
        gp_check(1'b0);
        w = rhit();
        push(1'b0, w);
        hit_valid_in <= 1'b0;
        gsel = 8'hE4;
        apb(1'b1, ADDR_GP_SEL, {24'h0, gsel});
        fork
            daq.gate(6);
            gp_check(1'b1);
        join
        rdc(ADDR_RD_DATA, w, 1'b0);
        w = rhit();
        push(1'b0, {HDR_MARK, w[24:0]});
        push(1'b1, w);
        hdr_valid_in <= 1'b0;
        rdc(ADDR_RD_DATA, exp_rec(1'b1, w), 1'b0);
        chk(daq.is_header(r), 1'b1);
        rdc(ADDR_STATUS, 32'h1, 1'b0);
        for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
            w = rhit();
            e = 1'($urandom);
            push(e, w);
            q.push_back(exp_rec(e, w));
        end
        {hit_valid_in, hdr_valid_in} <= 2'b00;
        repeat (4) @(posedge clk_in);
        chk(rec_ready_out, 1'b0);
        rdc(ADDR_STATUS, 32'h2, 1'b0);
        while (q.size() > 0) rdc(ADDR_RD_DATA, q.pop_front(), 1'b0);
        rdc(ADDR_STATUS, 32'h1, 1'b0);
        for (int j = 1; j < 5; j++) begin
            v = 32'(j % 4);
            apb(1'b1, ADDR_CTRL, v);
            rdc(ADDR_BSCAN, {26'h0, v[1:0], v[1:0], v[1:0]}, 1'b0);
            repeat (40) @(posedge clk_in);
            for (int k = 0; k < 16; k++) begin
                @(posedge clk_in);
                if (v == 1) chk(word[0] ^ word[1], 1'b1);
                if (v == 2) chk(word[0], word[6] ^ word[7]);
                if (v == 3) chk(word[0], word[28] ^ word[31]);
                chk(pump_a & pump_b, 1'b0);
            end
        end
        v = $urandom;
        apb(1'b1, ADDR_MON_SEL, v);
        repeat (2) @(posedge clk_in);
        chk(monitor_channel_select_out, v[3:0]);
        rdc(ADDR_MON_SEL, v[3:0], 1'b0);
        lock_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rdc(ADDR_STATUS, 32'h5, 1'b0);
        ce_in <= 1'b0;
        @(posedge clk_in);
        e = tx_bit_out;
        repeat (8) @(posedge clk_in) chk(tx_bit_out, e);
        ce_in <= 1'b1;
        waitw(svc(v[3:0], 1'b1, 2'h0), 600);
        apb(1'b1, ADDR_PULSES, $urandom);
        for (int k = 0; k < RO_NUM; k++) apb(1'b1, ADDR_RO_BASE + 8'(4 * k), $urandom);
        rdc(ADDR_PULSES, 32'h0, 1'b0);
        mask = 8'($urandom) | 8'h01;
        n = 1 + $urandom % 5;
        fork
            daq.gate(10 + 6 * n);
            begin
                repeat (4) @(posedge clk_in);
                ticks(mask, n);
            end
        join
        repeat (4) @(posedge clk_in);
        ticks(8'hFF, 3);
        for (int k = 0; k < RO_NUM; k++) rdc(ADDR_RO_BASE + 8'(4 * k), mask[k] ? n : 0, 1'b0);
        rdc(ADDR_PULSES, 32'h1, 1'b0);
        repeat (16) daq.gate(2);
        rdc(ADDR_PULSES, 32'h1, 1'b0);
        apb(1'b1, ADDR_RO_BASE, $urandom);
        rdc(ADDR_RO_BASE, 32'h0, 1'b0);
        tally_and_finish();
    end
endmodule // test_features_and_ring_osc_bench
